// ### alpha_decode_pkg.sv
// Purpose: Shared constants for the alpha-field character decoder.
// Assumes: One clock, synchronous active-high reset.
// Notes: Octets arrive as a stream; a field end flag marks the last octet of each field.
// Behaviour
// - Leading 0x80 means octet pairs are characters.
// - First octet of pair is upper byte.
// - Unused 0x80 octets hold 0xFF.
// - Even-length 0x80 field ends with 0xFF filler.
// - 0x81: count, then base bits 14 to 7.
// - 0x81 base has bit 15 and bits 6:0 clear.
// - 0x81 body: bit 7 selects alphabet or offset.
// - 0x82: count, then full 16-bit base pointer.
// - 0x82 body: bit 7 selects alphabet or offset.
// - 0xFF inside count decodes as base plus 0x7F.
// - One coding per record, never mixed.
// - Pure alphabet records carry no scheme header.
// - All three schemes supported for small sets.
package alpha_decode_pkg;

	// Leading octet values that select a coding scheme.
	localparam logic [7:0] SCHEME_PAIRS = 8'h80;
	localparam logic [7:0] SCHEME_HALF_PAGE = 8'h81;
	localparam logic [7:0] SCHEME_FULL_BASE = 8'h82;

	// Filler octet and the end marker pair of the pair scheme.
	localparam logic [7:0] FILL_OCTET = 8'hff;
	localparam logic [15:0] END_PAIR = 16'hffff;

	// Bit position that marks an offset octet, and the offset width.
	localparam int OFFSET_FLAG_BIT = 7;
	localparam int OFFSET_WIDTH = 7;

	// Shift that places the half-page octet at bits 14 to 7.
	localparam int HALF_PAGE_SHIFT = 7;

	// Decoder states.
	typedef enum logic [2:0] {
		ST_HEAD = 3'b000,
		ST_COUNT = 3'b001,
		ST_BASE_HI = 3'b010,
		ST_BASE_LO = 3'b011,
		ST_BODY = 3'b100,
		ST_PAIR_HI = 3'b101,
		ST_PAIR_LO = 3'b110,
		ST_DONE = 3'b111
	} state_type;

	// Scheme that the current record uses.
	typedef enum logic [1:0] {
		MODE_PLAIN = 2'b00,
		MODE_PAIRS = 2'b01,
		MODE_HALF = 2'b10,
		MODE_FULL = 2'b11
	} mode_type;

endpackage

// ### alpha_field_decoder.sv
// Purpose: Decodes a stored alpha-field octet string into characters.
// Assumes: Octets arrive one per valid cycle; FIELD_LAST marks the last octet.
// Notes: Characters leave as a registered stream with a wide/narrow flag.
`timescale 1ns/1ps

module alpha_field_decoder
	import alpha_decode_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic OCTET_VALID,
	input wire logic [7:0] OCTET_DATA,
	input wire logic FIELD_LAST,
	output logic CHAR_VALID,
	output logic CHAR_WIDE,
	output logic [15:0] CHAR_CODE,
	output logic STRING_DONE
);

	// Decoder state and its next value.
	state_type state_reg;
	state_type state_next;
	// Scheme chosen by the leading octet of the record.
	mode_type mode_reg;
	// Characters still owed in a counted scheme.
	logic [7:0] count_reg;
	// Base pointer of the counted schemes.
	logic [15:0] base_reg;
	// Upper byte held while the pair scheme waits for its lower byte.
	logic [7:0] upper_char_byte_reg;
	// Registered outputs of the pair and plain paths.
	logic direct_valid_reg;
	logic direct_wide_reg;
	logic [15:0] direct_code_reg;
	logic done_reg;
	// Body octet strobe for the counted expander.
	logic body_take;
	// Expander outputs.
	logic exp_valid;
	logic exp_wide;
	logic [15:0] exp_code;
	// Pair assembled from the held upper byte and the current octet.
	logic [15:0] pair_word;

	assign body_take = OCTET_VALID && (state_reg == ST_BODY) && (count_reg != 8'h00);
	assign pair_word = {upper_char_byte_reg, OCTET_DATA};

	////////////////////////////////////////////////////////////////////////////
	// Next state: the leading octet picks the scheme, then headers are walked.
	always_comb begin
		state_next = state_reg;
		if (OCTET_VALID) begin
			case (state_reg)
				ST_HEAD: begin
					if (OCTET_DATA == SCHEME_PAIRS) begin
						state_next = ST_PAIR_HI;
					end else if (OCTET_DATA == SCHEME_HALF_PAGE || OCTET_DATA == SCHEME_FULL_BASE) begin
						state_next = ST_COUNT;
					end else begin
						state_next = ST_BODY;
					end
				end
				ST_COUNT: begin
					state_next = ST_BASE_HI;
				end
				ST_BASE_HI: begin
					state_next = (mode_reg == MODE_FULL) ? ST_BASE_LO : ST_BODY;
				end
				ST_BASE_LO: begin
					state_next = ST_BODY;
				end
				ST_BODY: begin
					if (mode_reg != MODE_PLAIN && (count_reg == 8'h01 || count_reg == 8'h00)) begin
						state_next = ST_DONE;
					end
				end
				ST_PAIR_HI: begin
					state_next = ST_PAIR_LO;
				end
				ST_PAIR_LO: begin
					state_next = (pair_word == END_PAIR) ? ST_DONE : ST_PAIR_HI;
				end
				default: begin
					state_next = ST_DONE;
				end
			endcase
			if (FIELD_LAST) begin
				state_next = ST_HEAD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; one record uses one scheme until its field ends.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_reg <= ST_HEAD;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scheme latch taken from the leading octet.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			mode_reg <= MODE_PLAIN;
		end else if (OCTET_VALID && state_reg == ST_HEAD) begin
			if (OCTET_DATA == SCHEME_PAIRS) begin
				mode_reg <= MODE_PAIRS;
			end else if (OCTET_DATA == SCHEME_HALF_PAGE) begin
				mode_reg <= MODE_HALF;
			end else if (OCTET_DATA == SCHEME_FULL_BASE) begin
				mode_reg <= MODE_FULL;
			end else begin
				mode_reg <= MODE_PLAIN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Character count: loaded from the second octet, counted down per body octet.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			count_reg <= 8'h00;
		end else if (OCTET_VALID && state_reg == ST_COUNT) begin
			count_reg <= OCTET_DATA;
		end else if (body_take && mode_reg != MODE_PLAIN) begin
			count_reg <= count_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Base pointer: half-page octet placed at bits 14 to 7, or full 16 bits.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			base_reg <= 16'h0000;
		end else if (OCTET_VALID && state_reg == ST_BASE_HI) begin
			if (mode_reg == MODE_HALF) begin
				base_reg <= 16'({OCTET_DATA, 7'h00});
			end else begin
				base_reg <= {OCTET_DATA, 8'h00};
			end
		end else if (OCTET_VALID && state_reg == ST_BASE_LO) begin
			base_reg <= {base_reg[15:8], OCTET_DATA};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Upper byte of a pair is held until its lower byte arrives.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			upper_char_byte_reg <= 8'h00;
		end else if (OCTET_VALID && state_reg == ST_PAIR_HI) begin
			upper_char_byte_reg <= OCTET_DATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Direct path: completed pairs and plain pass-through octets.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			direct_valid_reg <= 1'b0;
			direct_wide_reg <= 1'b0;
			direct_code_reg <= 16'h0000;
		end else begin
			direct_valid_reg <= 1'b0;
			if (OCTET_VALID && state_reg == ST_PAIR_LO && pair_word != END_PAIR) begin
				direct_valid_reg <= 1'b1;
				direct_wide_reg <= 1'b1;
				direct_code_reg <= pair_word;
			end else if (OCTET_VALID && state_reg == ST_BODY && mode_reg == MODE_PLAIN) begin
				direct_valid_reg <= 1'b1;
				direct_wide_reg <= 1'b0;
				direct_code_reg <= {8'h00, OCTET_DATA};
			end else if (OCTET_VALID && state_reg == ST_HEAD && OCTET_DATA != SCHEME_PAIRS &&
				OCTET_DATA != SCHEME_HALF_PAGE && OCTET_DATA != SCHEME_FULL_BASE) begin
				// A plain leading octet is emitted even when it is the whole field.
				direct_valid_reg <= 1'b1;
				direct_wide_reg <= 1'b0;
				direct_code_reg <= {8'h00, OCTET_DATA};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// End-of-string pulse, one cycle after the octet that ends the string.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= OCTET_VALID && state_reg != ST_DONE &&
				(FIELD_LAST || state_next == ST_DONE);
		end
	end

	// Expander for the counted schemes.
	octet_expand expand_inst (
		.clk(CORE_CLK),
		.reset(RESET),
		.octet_valid(body_take && mode_reg != MODE_PLAIN),
		.octet(OCTET_DATA),
		.base_pointer(base_reg),
		.char_valid_reg(exp_valid),
		.char_wide_reg(exp_wide),
		.char_code_reg(exp_code)
	);

	// The two paths never fire together, so a plain select merges them.
	assign CHAR_VALID = direct_valid_reg | exp_valid;
	assign CHAR_WIDE = exp_valid ? exp_wide : direct_wide_reg;
	assign CHAR_CODE = exp_valid ? exp_code : direct_code_reg;
	assign STRING_DONE = done_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks kept beside the logic.
	sequence s_half_head;
		OCTET_VALID && state_reg == ST_BASE_HI && mode_reg == MODE_HALF;
	endsequence

	AST_HALF_BASE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		s_half_head |=> (base_reg[15] == 1'b0 && base_reg[6:0] == 7'h00 &&
		base_reg[14:7] == $past(OCTET_DATA)))
		else $error("Half-page base has stray bits.");

	AST_PAIR_OUT: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(OCTET_VALID && state_reg == ST_PAIR_LO && pair_word != END_PAIR) |=>
		(CHAR_VALID && CHAR_WIDE && CHAR_CODE == $past(pair_word)))
		else $error("Pair character wrong.");

	AST_PAIR_END: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(OCTET_VALID && state_reg == ST_PAIR_LO && pair_word == END_PAIR) |=>
		(!CHAR_VALID && STRING_DONE))
		else $error("End pair not honoured.");

	AST_COUNT_STOP: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(OCTET_VALID && state_reg == ST_DONE) |=> !CHAR_VALID)
		else $error("Character after count reached.");

	AST_OFFSET_CHAR: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(body_take && mode_reg != MODE_PLAIN && OCTET_DATA[OFFSET_FLAG_BIT]) |=>
		(CHAR_WIDE && CHAR_CODE == $past(base_reg) + 16'($past(OCTET_DATA[6:0]))))
		else $error("Offset character wrong.");

	AST_NARROW_CHAR: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(body_take && mode_reg != MODE_PLAIN && !OCTET_DATA[OFFSET_FLAG_BIT]) |=>
		(CHAR_VALID && !CHAR_WIDE && CHAR_CODE[15:7] == 9'h000))
		else $error("Alphabet character wrong.");

	AST_PLAIN_PASS: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(OCTET_VALID && state_reg == ST_HEAD && OCTET_DATA != SCHEME_PAIRS &&
		OCTET_DATA != SCHEME_HALF_PAGE && OCTET_DATA != SCHEME_FULL_BASE) |=>
		(CHAR_VALID && !CHAR_WIDE && CHAR_CODE == {8'h00, $past(OCTET_DATA)}))
		else $error("Plain octet not passed.");

	AST_FULL_BASE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(OCTET_VALID && state_reg == ST_BASE_LO) |=> (base_reg[7:0] == $past(OCTET_DATA)))
		else $error("Full base low byte wrong.");

endmodule

// ### alpha_field_decoder_test.sv
// Purpose: Self-checking bench for the alpha-field decoder.
// Assumes: Expected characters come from an integer model of the three schemes.
// Notes: Every field must give exactly one end-of-string pulse.
`timescale 1ns/1ps

module alpha_field_decoder_test;
	import alpha_decode_pkg::*;
	typedef logic [7:0] field_type[$];
	logic CORE_CLK = 1'b0;
	logic RESET = 1'b1;
	logic OCTET_VALID, FIELD_LAST, CHAR_VALID, CHAR_WIDE, STRING_DONE;
	logic [7:0] OCTET_DATA;
	logic [15:0] CHAR_CODE;
	logic slow = 1'b0;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	int errors = 0, total_checks = 0, cycles = 0, done_seen = 0, done_exp = 0;

	always #4 CORE_CLK = ~CORE_CLK;

	octet_source octet_source_inst (.clk(CORE_CLK), .slow(slow), .octet_valid(OCTET_VALID),
		.octet_data(OCTET_DATA), .field_last(FIELD_LAST));
	alpha_field_decoder alpha_field_decoder_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.OCTET_VALID(OCTET_VALID), .OCTET_DATA(OCTET_DATA), .FIELD_LAST(FIELD_LAST),
		.CHAR_VALID(CHAR_VALID), .CHAR_WIDE(CHAR_WIDE), .CHAR_CODE(CHAR_CODE),
		.STRING_DONE(STRING_DONE));

	////////////////////////////////////////////////////////////////////////////////
	// Compare one value and report a mismatch at once.
	task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Print the verdict and stop.
	task automatic conclude();
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Queue a field in the source and its expected characters in the model.
	task automatic send(input field_type f);
		int n, hdr, cnt, em, k;
		logic [15:0] base, w;
		n = f.size();
		em = 0;
		done_exp++;
		for (k = 0; k < n; k++) begin
			octet_source_inst.field_q.push_back({k == n - 1, f[k]});
		end
		if (f[0] == SCHEME_PAIRS) begin
			for (k = 1; k + 1 < n; k += 2) begin
				w = {f[k], f[k + 1]};
				if (w == END_PAIR) break;
				exp_q.push_back({1'b1, w});
			end
		end else if (f[0] == SCHEME_HALF_PAGE || f[0] == SCHEME_FULL_BASE) begin
			hdr = (f[0] == SCHEME_FULL_BASE) ? 4 : 3;
			if (n >= hdr) begin
				cnt = f[1];
				base = (hdr == 3) ? {1'b0, f[2], 7'h00} : {f[2], f[3]};
				for (k = hdr; k < n && em < cnt; k++) begin
					em++;
					if (f[k][7]) exp_q.push_back({1'b1, base + {9'h000, f[k][6:0]}});
					else exp_q.push_back({1'b0, 9'h000, f[k][6:0]});
				end
			end
		end else begin
			for (k = 0; k < n; k++) exp_q.push_back({1'b0, 8'h00, f[k]});
		end
	endtask

	// Wait until all octets are out, then settle and compare totals.
	task automatic flush();
		int t;
		t = 0;
		while ((octet_source_inst.field_q.size() != 0 || OCTET_VALID) && t < 2000) begin
			@(posedge CORE_CLK);
			t++;
		end
		repeat (3) @(posedge CORE_CLK);
		check("drained", t < 2000, 1);
		check("chars_left", exp_q.size(), 0);
		check("done_count", done_seen, done_exp);
	endtask

	// Build a random field of a given scheme.
	task automatic rand_field(input int kind);
		field_type f;
		int n;
		n = $urandom_range(12, 1);
		case (kind)
			0: f.push_back(SCHEME_PAIRS);
			1: f.push_back(SCHEME_HALF_PAGE);
			2: f.push_back(SCHEME_FULL_BASE);
			default: f.push_back(8'($urandom_range(8'h7f, 0)));
		endcase
		while (f.size() < n) f.push_back(8'($urandom_range(255, 0)));
		if (kind == 1 || kind == 2) begin
			if (n > 1) f[1] = 8'($urandom_range(10, 0));
		end
		send(f);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Every character is compared with the model; end pulses are counted.
	always @(negedge CORE_CLK) begin
		if (RESET) begin
			check("idle_in_reset", {CHAR_VALID, STRING_DONE}, 0);
		end else begin
			check("flags_known", {CHAR_VALID, STRING_DONE} ^ {CHAR_VALID, STRING_DONE}, 0);
			if (STRING_DONE === 1'b1) done_seen++;
			if (CHAR_VALID === 1'b1) begin
				e = (exp_q.size() != 0) ? exp_q.pop_front() : 17'h1dead;
				check("char", {CHAR_WIDE, CHAR_CODE}, e);
			end
		end
	end

	// Cut a hang short.
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles >= 20000) begin
			errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: worked examples, boundaries, then random fields.
	initial begin
		void'($urandom(32'hf92b));
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		@(posedge CORE_CLK);
		send('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h41, 8'hff, 8'hff});
		send('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d, 8'h31});
		send('{8'h80, 8'h09, 8'h95, 8'h00, 8'h41, 8'h30, 8'h53, 8'hff, 8'hff});
		send('{8'h80, 8'h12, 8'h34, 8'h56, 8'h78, 8'hff});
		send('{8'h81, 8'h00, 8'h13, 8'h41, 8'hc2});
		send('{8'h41, 8'h42});
		send('{8'hc5, 8'h10});
		send('{8'h2a});
		send('{8'h82, 8'h03, 8'h12, 8'h34});
		flush();
		for (int i = 0; i < 48; i++) begin
			slow <= i[0];
			rand_field(i % 4);
			if (i % 8 == 7) flush();
		end
		flush();
		conclude();
	end
endmodule

// ### octet_expand.sv
// Purpose: Turns one body octet of a counted string into a character.
// Assumes: Base pointer is stable while the octet is presented.
// Notes: Output is registered; one cycle from octet to character.
`timescale 1ns/1ps

module octet_expand
	import alpha_decode_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic octet_valid,
	input wire logic [7:0] octet,
	input wire logic [15:0] base_pointer,
	output logic char_valid_reg,
	output logic char_wide_reg,
	output logic [15:0] char_code_reg
);

	// Offset bits taken from the octet, widened to the code width.
	logic [15:0] offset;

	assign offset = {{(16 - OFFSET_WIDTH){1'b0}}, octet[OFFSET_WIDTH-1:0]};

	////////////////////////////////////////////////////////////////////////////
	// Bit 7 clear gives an alphabet character; set gives base plus offset.
	// An 0xff octet falls in the second branch and yields base plus 0x7f.
	always_ff @(posedge clk) begin
		if (reset) begin
			char_valid_reg <= 1'b0;
			char_wide_reg <= 1'b0;
			char_code_reg <= 16'h0000;
		end else begin
			char_valid_reg <= octet_valid;
			if (octet_valid) begin
				if (octet[OFFSET_FLAG_BIT]) begin
					char_wide_reg <= 1'b1;
					char_code_reg <= base_pointer + offset;
				end else begin
					char_wide_reg <= 1'b0;
					char_code_reg <= offset;
				end
			end
		end
	end

endmodule

// ### octet_source.sv
// Purpose: Behavioural model of the card record store feeding field octets.
// Assumes: The bench loads whole fields into the queue, one flag per octet end.
// Notes: In slow mode idle cycles are inserted at random between octets.
`timescale 1ns/1ps

module octet_source (
	input wire logic clk,
	input wire logic slow,
	output logic octet_valid,
	output logic [7:0] octet_data,
	output logic field_last
);
	// Queued octets, bit 8 marks the last octet of a field.
	logic [8:0] field_q[$];
	// Last octet sent, so idle data can be made to differ from it.
	logic [7:0] last_octet;
	// Entry taken from the queue this cycle.
	logic [8:0] entry;

	////////////////////////////////////////////////////////////////////////////////
	// Start idle so nothing is offered before the bench loads a field.
	initial begin
		octet_valid = 1'b0;
		octet_data = 8'h00;
		field_last = 1'b0;
		last_octet = 8'h00;
	end

	// Offer one octet per cycle, or idle when stalled or empty.
	// Fields are stored whole, with one coding each and filler as loaded.
	always @(posedge clk) begin
		if (field_q.size() != 0 && !(slow && $urandom_range(1, 0) == 0)) begin
			entry = field_q.pop_front();
			octet_valid <= 1'b1;
			octet_data <= entry[7:0];
			field_last <= entry[8];
			last_octet <= entry[7:0];
		end else begin
			// Idle data is the inverse of the last octet, never a held copy.
			octet_valid <= 1'b0;
			octet_data <= ~last_octet;
			field_last <= 1'b0;
		end
	end
endmodule
